// ===== common/ext_bus_cfg.svh
// Constants for the external memory bus and data space decoder
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define DIRECT_RAM_TOP   8'h7f
`define BIT_BYTE_BASE    8'h20
`define BIT_LOW_TOP      8'h7f
`define BANK_POS         3
`define EXTRA_RAM_SIZE   17'h00800
`define EEPROM_SIZE      17'h01000
`define PROG_EXT_BASE    16'h8000
`define USER_SIG_SIZE    10'h200
`define FACT_SIG_SIZE    10'h080
`define ALE_PERIOD       2'h3
`define FETCH_WAITS      2'h2
`endif

// ===== common/ext_bus_pkg.sv
// Types for the external memory bus and data space decoder
package ext_bus_pkg;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       paged;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xreq_type;
  typedef struct packed {
    logic       direct;
    logic [7:0] addr;
    logic       reg_mode;
    logic [2:0] reg_num;
    logic       bit_mode;
  } iacc_type;
  typedef struct packed {
    logic       ram_sel;
    logic       sfr_sel;
    logic [7:0] ram_addr;
  } idec_type;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_STRB  = 4'b0100,
    ST_DONE  = 4'b1000
  } bus_state_type;
endpackage

// ===== rtl/ext_memory_bus.sv
// External memory bus engine and internal data space decoder
`timescale 1ns/1ns
`include "ext_bus_cfg.svh"
module ext_memory_bus #(
  parameter int EXTRA_RAM_BYTES = 2048,
  parameter int EEPROM_BYTES    = 4096
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  input  wire ext_bus_pkg::xreq_type  i_xreq,
  input  wire ext_bus_pkg::iacc_type  i_iacc,
  input  wire logic [7:0]             i_program_status_word,
  input  wire logic                   i_latch_strobe_off,
  input  wire logic                   i_external_ram_force,
  input  wire logic                   i_latch_strobe_disable,
  input  wire logic [1:0]             i_wait_state_select,
  input  wire logic                   i_fast_mode,
  input  wire logic                   i_fetch_req,
  input  wire logic [15:0]            i_fetch_addr,
  input  wire logic [15:0]            i_exec_pc,
  input  wire logic                   i_fbs_wr,
  input  wire logic                   i_fbs_wdata,
  input  wire logic                   i_sig_wr,
  input  wire logic [9:0]             i_sig_addr,
  input  wire logic                   i_sig_lock,
  input  wire logic                   i_prog_read,
  input  wire logic [7:0]             i_p0_in,
  output logic [7:0]                  o_p0_out,
  output logic                        o_p0_oe,
  output logic [7:0]                  o_p2_out,
  output logic                        o_p2_oe,
  output logic                        o_latch_strobe,
  output logic                        o_latch_strobe_oe,
  output logic                        o_read_strobe_n,
  output logic                        o_write_strobe_n,
  output logic                        o_program_fetch_strobe_n,
  output logic                        o_xbusy,
  output logic                        o_xdone,
  output logic [7:0]                  o_xrdata,
  output logic                        o_int_extra,
  output logic                        o_int_eeprom,
  output ext_bus_pkg::idec_type       o_idec,
  output logic                        o_fetch_bank_select,
  output logic                        o_fetch_external,
  output logic                        o_fetch_wait,
  output logic                        o_sig_wr_ok,
  output logic                        o_sig_rd_ok
);
  import ext_bus_pkg::*;

  // ----------------------------------------
  // Internal data space decode
  // ----------------------------------------
  idec_type idec_d;
  always_comb begin
    idec_d = '0;
    if (i_iacc.reg_mode) begin
      idec_d.ram_sel  = 1'b1;
      idec_d.ram_addr = {3'h0, i_program_status_word[`BANK_POS+1:`BANK_POS], i_iacc.reg_num};
    end else if (i_iacc.bit_mode) begin
      if (i_iacc.addr <= `BIT_LOW_TOP) begin
        idec_d.ram_sel  = 1'b1;
        idec_d.ram_addr = `BIT_BYTE_BASE + {3'h0, i_iacc.addr[7:3]};
      end else begin
        idec_d.sfr_sel  = 1'b1;
        idec_d.ram_addr = {i_iacc.addr[7:3], 3'h0};
      end
    end else if (i_iacc.direct) begin
      idec_d.ram_sel  = (i_iacc.addr <= `DIRECT_RAM_TOP);
      idec_d.sfr_sel  = (i_iacc.addr > `DIRECT_RAM_TOP);
      idec_d.ram_addr = i_iacc.addr;
    end else begin
      // Indirect reaches all RAM, stack included
      idec_d.ram_sel  = 1'b1;
      idec_d.ram_addr = i_iacc.addr;
    end
  end

  // ----------------------------------------
  // Fetch bank and signature access
  // ----------------------------------------
  logic fbs_q, fbs_d;
  logic fext_q, fext_d;
  logic sigw_q, sigw_d, sigr_q, sigr_d;
  always_comb begin
    fbs_d = fbs_q;
    if (i_fbs_wr && i_exec_pc < `PROG_EXT_BASE) begin
      fbs_d = i_fbs_wdata;
    end
    fext_d = i_fetch_req && fbs_q && (i_fetch_addr >= `PROG_EXT_BASE);
    sigw_d = i_sig_wr && !i_sig_lock && (i_sig_addr < `USER_SIG_SIZE + `FACT_SIG_SIZE);
    sigr_d = i_prog_read && (i_sig_addr < `USER_SIG_SIZE + `FACT_SIG_SIZE);
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fbs_q  <= 1'b0;
      fext_q <= 1'b0;
      sigw_q <= 1'b0;
      sigr_q <= 1'b0;
    end else begin
      fbs_q  <= fbs_d;
      fext_q <= fext_d;
      sigw_q <= sigw_d;
      sigr_q <= sigr_d;
    end
  end

  // ----------------------------------------
  // External bus sequencer
  // ----------------------------------------
  bus_state_type st_q, st_d;
  xreq_type   req_q, req_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [7:0] p0_q, p0_d, p2_q, p2_d, rd_q, rd_d;
  logic       p0oe_q, p0oe_d, p2oe_q, p2oe_d;
  logic       ale_q, ale_d, aleoe_q, aleoe_d;
  logic       rdn_q, rdn_d, wrn_q, wrn_d, psn_q, psn_d;
  logic       done_q, done_d, ie_q, ie_d, ee_q, ee_d;
  logic       go_ext;
  logic       busy_q, busy_d;
  logic [16:0] a17;

  always_comb begin
    a17 = {1'b0, i_xreq.addr};
    // The EEPROM range starts where the extra RAM ends, so the EEPROM top bounds them both
    go_ext = i_external_ram_force || (a17 >= 17'(EEPROM_BYTES));
  end

  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    cnt_d  = cnt_q;
    p0_d   = p0_q;
    p2_d   = p2_q;
    rd_d   = rd_q;
    p0oe_d = p0oe_q;
    p2oe_d = p2oe_q;
    rdn_d  = 1'b1;
    wrn_d  = 1'b1;
    done_d = 1'b0;
    ie_d   = 1'b0;
    ee_d   = 1'b0;
    ph_d   = (ph_q == `ALE_PERIOD - 2'h1) ? 2'h0 : ph_q + 2'h1;
    psn_d  = 1'b1;
    // Idle strobe free-runs unless parked high; parking avoids a runt on the jump
    ale_d   = i_latch_strobe_off ? 1'b1 : (ph_d == 2'h0);
    aleoe_d = !i_latch_strobe_off && !i_latch_strobe_disable;
    if (fext_q) begin
      ale_d   = (ph_d == 2'h0);
      aleoe_d = 1'b1;
      // A three-cycle period cannot split evenly; strobe is low two of three
      psn_d   = (ph_d == 2'h0);
      p2_d    = i_fetch_addr[15:8];
      p2oe_d  = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        p0oe_d = 1'b0;
        // A request still held while done shows is the one just finished
        if (i_xreq.valid && !done_q) begin
          if (i_xreq.paged || go_ext) begin
            st_d    = ST_ADDR;
            req_d   = i_xreq;
            ale_d   = 1'b1;
            aleoe_d = 1'b1;
            p0_d   = i_xreq.addr[7:0];
            p0oe_d = 1'b1;
            if (!i_xreq.paged) begin
              p2_d   = i_xreq.addr[15:8];
              p2oe_d = 1'b1;
            end
          end else begin
            done_d = 1'b1;
            ie_d   = (a17 < 17'(EXTRA_RAM_BYTES));
            ee_d   = !(a17 < 17'(EXTRA_RAM_BYTES));
          end
        end
      end
      ST_ADDR: begin
        // Strobe falls on the same edge that port 0 swaps the address for write data, or is released on a read
        ale_d   = 1'b0;
        aleoe_d = 1'b1;
        st_d    = ST_STRB;
        cnt_d   = i_wait_state_select;
        p0_d    = req_q.wdata;
        p0oe_d  = req_q.write;
        rdn_d   = req_q.write;
        wrn_d   = !req_q.write;
      end
      ST_STRB: begin
        ale_d   = 1'b0;
        aleoe_d = 1'b1;
        rdn_d   = req_q.write;
        wrn_d   = !req_q.write;
        if (cnt_q == 2'h0) begin
          rdn_d = 1'b1;
          wrn_d = 1'b1;
          if (!req_q.write) begin
            rd_d = i_p0_in;
          end
          st_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      ST_DONE: begin
        p0oe_d = 1'b0;
        p2oe_d = fext_q;
        done_d = 1'b1;
        st_d   = ST_IDLE;
      end
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q    <= ST_IDLE;
      req_q   <= '0;
      cnt_q   <= 2'h0;
      ph_q    <= 2'h0;
      p0_q    <= 8'h00;
      p2_q    <= 8'h00;
      rd_q    <= 8'h00;
      p0oe_q  <= 1'b0;
      p2oe_q  <= 1'b0;
      ale_q   <= 1'b1;
      aleoe_q <= 1'b0;
      rdn_q   <= 1'b1;
      wrn_q   <= 1'b1;
      psn_q   <= 1'b1;
      done_q  <= 1'b0;
      ie_q    <= 1'b0;
      busy_q  <= 1'b0;
      ee_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      req_q   <= req_d;
      cnt_q   <= cnt_d;
      ph_q    <= ph_d;
      p0_q    <= p0_d;
      p2_q    <= p2_d;
      rd_q    <= rd_d;
      p0oe_q  <= p0oe_d;
      p2oe_q  <= p2oe_d;
      ale_q   <= ale_d;
      aleoe_q <= aleoe_d;
      rdn_q   <= rdn_d;
      wrn_q   <= wrn_d;
      psn_q   <= psn_d;
      done_q  <= done_d;
      ie_q    <= ie_d;
      ee_q    <= ee_d;
      busy_q  <= busy_d;
    end
  end

  logic       wait_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= fext_d && i_fast_mode && (ph_d != `FETCH_WAITS);
    end
  end

  idec_type idec_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idec_q <= '0;
    end else begin
      idec_q <= idec_d;
    end
  end

  assign o_p0_out                 = p0_q;
  assign o_p0_oe                  = p0oe_q;
  assign o_p2_out                 = p2_q;
  assign o_p2_oe                  = p2oe_q;
  assign o_latch_strobe           = ale_q;
  assign o_latch_strobe_oe        = aleoe_q;
  assign o_read_strobe_n          = rdn_q;
  assign o_write_strobe_n         = wrn_q;
  assign o_program_fetch_strobe_n = psn_q;
  assign o_xbusy                  = busy_q;
  assign o_xdone                  = done_q;
  assign o_xrdata                 = rd_q;
  assign o_int_extra              = ie_q;
  assign o_int_eeprom             = ee_q;
  assign o_idec                   = idec_q;
  assign o_fetch_bank_select      = fbs_q;
  assign o_fetch_external         = fext_q;
  assign o_fetch_wait             = wait_q;
  assign o_sig_wr_ok              = sigw_q;
  assign o_sig_rd_ok              = sigr_q;
endmodule

// ===== sim/ext_memory_bus_asserts.sv
// Port timing checks for the external bus engine and data decoder
`timescale 1ns/1ns
module ext_memory_bus_asserts (
  input wire logic                  i_clk,
  input wire logic                  i_rstn,
  input wire ext_bus_pkg::xreq_type i_xreq,
  input wire ext_bus_pkg::iacc_type i_iacc,
  input wire logic                  i_latch_strobe_off,
  input wire logic [1:0]            i_wait_state_select,
  input wire logic [15:0]           i_exec_pc,
  input wire logic                  i_fbs_wr,
  input wire logic                  i_fbs_wdata,
  input wire logic                  o_p0_oe,
  input wire logic                  o_latch_strobe,
  input wire logic                  o_read_strobe_n,
  input wire logic                  o_write_strobe_n,
  input wire logic                  o_xbusy,
  input wire ext_bus_pkg::idec_type o_idec,
  input wire logic                  o_fetch_bank_select
);
  import ext_bus_pkg::*;
  logic [2:0] low_q;
  logic [2:0] low_d;
  logic       idle;
  // Strobe-low cycles, judged when the strobe rises
  always_comb low_d = (o_read_strobe_n && o_write_strobe_n) ? 3'h0 : low_q + 3'h1;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) low_q <= 3'h0;
    else low_q <= low_d;
  end
  assign idle = !o_xbusy && !i_xreq.valid && !i_latch_strobe_off;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  strobe_excl_a: assert property (o_read_strobe_n || o_write_strobe_n)
    else $error("both strobes low");
  read_release_a: assert property (!o_read_strobe_n |-> !o_p0_oe)
    else $error("port 0 driven in read");
  strobe_width_a: assert property ($rose(o_read_strobe_n && o_write_strobe_n)
    |-> low_q == {1'b0, i_wait_state_select} + 3'h1) else $error("strobe width wrong");
  idle_period_a: assert property (idle [*5] |-> o_latch_strobe == $past(o_latch_strobe, 3))
    else $error("idle latch strobe not periodic");
  fbs_lock_a: assert property (i_fbs_wr && i_exec_pc >= 16'h8000 |=> $stable(o_fetch_bank_select))
    else $error("bank select changed from upper code");
  fbs_set_a: assert property (i_fbs_wr && i_exec_pc < 16'h8000 |=> o_fetch_bank_select == $past(i_fbs_wdata))
    else $error("bank select not written");
  sfr_select_a: assert property (i_iacc.direct && i_iacc.addr[7] && !i_iacc.reg_mode && !i_iacc.bit_mode
    |=> o_idec.sfr_sel && !o_idec.ram_sel) else $error("direct upper not to registers");
  indirect_ram_a: assert property (!i_iacc.direct && !i_iacc.reg_mode && !i_iacc.bit_mode
    |=> o_idec.ram_sel && o_idec.ram_addr == $past(i_iacc.addr)) else $error("indirect not to RAM");
endmodule
bind ext_memory_bus ext_memory_bus_asserts u_chk (.*);

// ===== sim/ext_ram_model.sv
// External RAM with address latch on the multiplexed bus
`timescale 1ns/1ns
module ext_ram_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_p0_out,
  input  wire logic       i_p0_oe,
  input  wire logic [7:0] i_p2_out,
  input  wire logic [7:0] i_page,
  input  wire logic       i_paged,
  input  wire logic       i_ale,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [1:0] i_lag,
  output logic      [7:0] o_p0_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [7:0] last_q = 8'h5a;
  logic [2:0] cnt_q = 3'h0;
  always @(posedge i_clk) begin
    if (i_ale && i_p0_oe) begin
      lo_q <= i_p0_out;
      hi_q <= i_paged ? i_page : i_p2_out;
    end
    if (!i_wr_n) mem[{hi_q, lo_q}] <= i_p0_out;
    cnt_q <= i_rd_n ? 3'h0 : cnt_q + 3'h1;
    last_q <= o_p0_in;
  end
  // Slow part: junk until i_lag cycles of strobe; no pull-up, so a released bus flips
  assign o_p0_in = (!i_rd_n && cnt_q >= {1'b0, i_lag}) ? mem[{hi_q, lo_q}] : ~last_q;
endmodule

// ===== sim/tb.sv
// Self-checking bench for the external bus engine and data decoder
`timescale 1ns/1ns
module tb;
  import ext_bus_pkg::*;
  logic        i_clk, i_rstn, i_latch_strobe_off, i_external_ram_force, i_latch_strobe_disable;
  logic        i_fast_mode, i_fetch_req, i_fbs_wr, i_fbs_wdata, i_sig_wr, i_sig_lock, i_prog_read;
  logic        o_p0_oe, o_latch_strobe, o_latch_strobe_oe, o_read_strobe_n, o_write_strobe_n;
  logic        o_xdone, o_int_extra, o_int_eeprom, o_fetch_bank_select, o_sig_wr_ok, o_sig_rd_ok;
  logic        o_p2_oe, o_xbusy, o_program_fetch_strobe_n, o_fetch_external, o_fetch_wait;
  logic [1:0]  i_wait_state_select;
  logic [7:0]  i_program_status_word, i_p0_in, o_p0_out, o_p2_out, o_xrdata, page;
  logic [9:0]  i_sig_addr;
  logic [15:0] i_fetch_addr, i_exec_pc;
  xreq_type    i_xreq;
  iacc_type    i_iacc;
  idec_type    o_idec;
  int          errors = 0;
  int          check_count = 0;
  int          ale_hi = 0;
  int          psn_hi = 0;
  int          wait_hi = 0;
  ext_memory_bus u_dut (.*);
  ext_ram_model u_mem (.i_clk(i_clk), .i_p0_out(o_p0_out), .i_p0_oe(o_p0_oe), .i_p2_out(o_p2_out),
    .i_page(page), .i_paged(i_xreq.paged), .i_ale(o_latch_strobe), .i_rd_n(o_read_strobe_n),
    .i_wr_n(o_write_strobe_n), .i_lag(i_wait_state_select), .o_p0_in(i_p0_in));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until done is seen, as the handshake demands
  task automatic xfer(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] e);
    int n;
    @(posedge i_clk);
    i_xreq <= '{1'b1, w, p, a, d};
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      if (n == 2) chk(16'({o_xbusy, o_p2_oe}), 16'({e == 2'b00, e == 2'b00 && !p}));
    end while (o_xdone !== 1'b1 && n < 30);
    chk(16'(o_xdone), 16'h1);
    chk(16'({o_int_eeprom, o_int_extra}), 16'(e));
    if (!w && e == 2'b00) chk(16'(o_xrdata), 16'(d));
    @(posedge i_clk);
    i_xreq.valid <= 1'b0;
  endtask
  task automatic dec(input iacc_type a, input idec_type e);
    @(posedge i_clk);
    i_iacc <= a;
    @(posedge i_clk);
    @(negedge i_clk);
    chk({6'h0, o_idec.ram_sel, o_idec.sfr_sel, e.ram_sel ? o_idec.ram_addr : 8'h00}, 16'(e));
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    $display("MISMATCH at %0t: run hung", $time);
    wrap_up();
  end
  initial begin
    i_rstn = 1'b0;
    {i_latch_strobe_off, i_external_ram_force, i_latch_strobe_disable, i_fast_mode, i_fetch_req} = '0;
    {i_fbs_wr, i_fbs_wdata, i_sig_wr, i_sig_lock, i_prog_read, i_wait_state_select, page} = '0;
    {i_program_status_word, i_fetch_addr, i_exec_pc} = '0;
    i_sig_addr = 10'h1ff;
    i_xreq = '0;
    i_iacc = '{1'b1, 8'h00, 1'b0, 3'h0, 1'b0};
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    xfer(1'b0, 1'b0, 16'h07ff, 8'h00, 2'b01);
    xfer(1'b0, 1'b0, 16'h0800, 8'h00, 2'b10);
    xfer(1'b0, 1'b0, 16'h0fff, 8'h00, 2'b10);
    i_external_ram_force <= 1'b1;
    xfer(1'b1, 1'b0, 16'h07ff, 8'ha5, 2'b00);
    xfer(1'b0, 1'b0, 16'h07ff, 8'ha5, 2'b00);
    i_external_ram_force <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      i_wait_state_select <= k[1:0];
      xfer(1'b1, 1'b0, {8'h10 + k[7:0], 8'h00}, 8'hc3 ^ k[7:0], 2'b00);
      xfer(1'b0, 1'b0, {8'h10 + k[7:0], 8'h00}, 8'hc3 ^ k[7:0], 2'b00);
    end
    page <= 8'h56;
    xfer(1'b1, 1'b1, 16'h0078, 8'h9e, 2'b00);
    xfer(1'b0, 1'b0, 16'h5678, 8'h9e, 2'b00);
    i_program_status_word <= 8'h10;
    dec('{1'b1, 8'h7f, 1'b0, 3'h0, 1'b0}, '{1'b1, 1'b0, 8'h7f});
    dec('{1'b1, 8'h80, 1'b0, 3'h0, 1'b0}, '{1'b0, 1'b1, 8'h00});
    dec('{1'b0, 8'h80, 1'b0, 3'h0, 1'b0}, '{1'b1, 1'b0, 8'h80});
    dec('{1'b0, 8'h00, 1'b1, 3'h5, 1'b0}, '{1'b1, 1'b0, 8'h15});
    dec('{1'b0, 8'h5b, 1'b0, 3'h0, 1'b1}, '{1'b1, 1'b0, 8'h2b});
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_sig_lock <= !k[0];
      i_sig_wr <= 1'b1;
      i_prog_read <= 1'b1;
      i_exec_pc <= k[0] ? 16'h7fff : 16'h8000;
      i_fbs_wr <= 1'b1;
      i_fbs_wdata <= 1'b1;
      @(posedge i_clk);
      {i_sig_wr, i_prog_read, i_fbs_wr} <= 3'h0;
      @(negedge i_clk);
      chk(16'({o_sig_wr_ok, o_sig_rd_ok}), {14'h0, k[0], 1'b1});
      chk(16'(o_fetch_bank_select), 16'(k[0]));
    end
    // External fetch with the upper bank mapped out
    @(posedge i_clk);
    {i_fetch_req, i_fast_mode, i_fetch_addr} <= {2'b11, 16'h9abc};
    repeat (3) @(posedge i_clk);
    repeat (6) begin
      @(negedge i_clk);
      ale_hi += int'(o_latch_strobe);
      psn_hi += int'(o_program_fetch_strobe_n);
      wait_hi += int'(o_fetch_wait);
    end
    chk(16'(ale_hi), 16'h2);
    chk(16'(psn_hi), 16'h2);
    chk(16'(wait_hi), 16'h4);
    chk({o_fetch_external, o_p2_oe, 6'h0, o_p2_out}, 16'hc09a);
    @(posedge i_clk);
    {i_fetch_req, i_fast_mode} <= 2'b00;
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_latch_strobe_off <= (k == 1);
      i_latch_strobe_disable <= (k == 2);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk(16'(o_latch_strobe_oe), 16'(k == 0));
      if (k == 1) chk(16'(o_latch_strobe), 16'h1);
    end
    wrap_up();
  end
endmodule
